// ==== common/mgs_pkg.sv ====
// package: constants for the gang synchronisation block
package mgs_pkg;
	// ------------------------------------------------------------
	// register byte offsets (apb, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] MGS_MAIN_CTRL_OFS = 8'h00;
	localparam logic [7:0] MGS_OP_STATUS_OFS = 8'h04;
	localparam logic [7:0] MGS_CAL_CTRL_OFS = 8'h08;
	// ------------------------------------------------------------
	// main control register fields
	// ------------------------------------------------------------
	localparam int MGS_CONV_EN_BIT = 0;
	localparam int MGS_POWER_EN_BIT = 1;
	localparam int MGS_GANG_BIT = 4;
	localparam int MGS_MASTER_BIT = 5;
	localparam logic [31:0] MGS_MAIN_CTRL_MASK = 32'h0000_0033;
	localparam logic [31:0] MGS_MAIN_CTRL_RST = 32'h0000_0000;
	// ------------------------------------------------------------
	// status fields
	// ------------------------------------------------------------
	localparam int MGS_LOCK_BIT = 0;
	localparam int MGS_RUN_BIT = 1;
	localparam int MGS_SYNCED_BIT = 2;
	localparam int MGS_MISSED_BIT = 3;
	localparam int MGS_IS_MASTER_BIT = 4;
	// ------------------------------------------------------------
	// calibration routing control fields
	// ------------------------------------------------------------
	localparam int MGS_CAL_OUT_BIT = 0;
	localparam int MGS_CAL_EXT_BIT = 1;
	localparam logic [31:0] MGS_CAL_CTRL_MASK = 32'h0000_0003;
	// ------------------------------------------------------------
	// timing: sync pulse width in ns, derived cycles at 250 mhz
	// ------------------------------------------------------------
	localparam int MGS_CLK_MHZ = 250;
	localparam int MGS_SYNC_PULSE_NS = 40;
	localparam int MGS_SYNC_CYC = (MGS_SYNC_PULSE_NS * MGS_CLK_MHZ) / 1000;
	localparam logic [3:0] MGS_SYNC_CYC_W = 4'(MGS_SYNC_CYC);
	// conversion states
	typedef enum logic [1:0] {
		MGS_IDLE,
		MGS_ARMED,
		MGS_RUN
	} mgs_state_e;
endpackage : mgs_pkg

// ==== rtl/mgs_gang_sync.sv ====
// gang mode master/slave coordination with apb registers
`timescale 1ns/1ns
module mgs_gang_sync
	import mgs_pkg::*;
#(
	parameter bit SLAVE_ONLY = 1'b0 // expansion-only variant
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog core status and control
	input wire logic pll_lock,
	output logic power_en,
	output logic conv_start,
	output logic conv_run,
	// conversion sync pin
	input wire logic sync_in,
	output logic sync_out,
	output logic sync_oe,
	// shared clock pin
	output logic clk_io_oe,
	// calibration dac pin
	output logic cal_io_oe,
	output logic cal_ext_sel
);
	import mgs_pkg::*;

	// ------------------------------------------------------------
	// registers and synchronised inputs
	// ------------------------------------------------------------
	logic [31:0] ctrl_r, ctrl_nxt; // main control register
	logic [31:0] cal_r, cal_nxt; // calibration routing control
	logic [31:0] prdata_nxt;
	logic missed_r, missed_nxt; // sync arrived while unlocked
	logic synced_r, synced_nxt; // slave aligned to master
	logic sync_q_r, sync_q_nxt; // previous synced sync level
	logic [3:0] pcnt_r, pcnt_nxt; // sync pulse width counter
	mgs_state_e st_r, st_nxt;
	logic sync_s, lock_s; // pin inputs after two flops
	logic is_master, gang_on, conv_en, wr, rd, sync_rise;

	mgs_sync2 u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.din(sync_in),
		.dout(sync_s)
	);
	mgs_sync2 u_lock (
		.clk(clk),
		.reset_n(reset_n),
		.din(pll_lock),
		.dout(lock_s)
	);

	// role select, forced slave on expansion variant
	assign is_master = ctrl_r[MGS_MASTER_BIT] & ~SLAVE_ONLY;
	// gang enable gates the sync and clock pin functions
	assign gang_on = ctrl_r[MGS_GANG_BIT];
	assign conv_en = ctrl_r[MGS_CONV_EN_BIT];
	assign power_en = ctrl_r[MGS_POWER_EN_BIT];
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign sync_rise = sync_s & ~sync_q_r;
	assign pready = 1'b1; // zero wait states
	assign pslverr = 1'b0;

	// ------------------------------------------------------------
	// register writes and read data
	// ------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		cal_nxt = cal_r;
		prdata_nxt = prdata;
		// decode write address
		if (wr && paddr == MGS_MAIN_CTRL_OFS) begin
			ctrl_nxt = pwdata & MGS_MAIN_CTRL_MASK;
		end else if (wr && paddr == MGS_CAL_CTRL_OFS) begin
			cal_nxt = pwdata & MGS_CAL_CTRL_MASK;
		end
		// read data is latched in setup, stable for the access phase
		if (rd) begin
			if (paddr == MGS_MAIN_CTRL_OFS) begin
				prdata_nxt = ctrl_r;
			end else if (paddr == MGS_OP_STATUS_OFS) begin
				prdata_nxt = '0;
				prdata_nxt[MGS_LOCK_BIT] = lock_s;
				prdata_nxt[MGS_RUN_BIT] = conv_run;
				prdata_nxt[MGS_SYNCED_BIT] = synced_r;
				prdata_nxt[MGS_MISSED_BIT] = missed_r;
				prdata_nxt[MGS_IS_MASTER_BIT] = is_master;
			end else if (paddr == MGS_CAL_CTRL_OFS) begin
				prdata_nxt = cal_r;
			end else begin
				// unmapped reads return zero
				prdata_nxt = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= MGS_MAIN_CTRL_RST;
			cal_r <= '0;
			prdata <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			cal_r <= cal_nxt;
			prdata <= prdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// conversion sequencing and sync generation
	// ------------------------------------------------------------
	// a master fires once per start; clearing conversion re-arms it
	always_comb begin
		st_nxt = st_r;
		pcnt_nxt = pcnt_r;
		synced_nxt = synced_r;
		missed_nxt = missed_r;
		sync_q_nxt = sync_s;
		conv_start = 1'b0;
		if (pcnt_r != 4'h0) begin
			pcnt_nxt = pcnt_r - 4'h1;
		end
		case (st_r)
			MGS_IDLE: begin
				synced_nxt = 1'b0;
				if (conv_en && gang_on && !is_master) begin
					st_nxt = MGS_ARMED;
				end else if (conv_en) begin
					// ganged master start fires one sync pulse
					st_nxt = MGS_RUN;
					conv_start = 1'b1;
					if (gang_on) begin
						pcnt_nxt = MGS_SYNC_CYC_W;
					end
				end
			end
			MGS_ARMED: begin
				if (!conv_en || !gang_on || is_master) begin
					st_nxt = MGS_IDLE;
				end else if (sync_rise && !lock_s) begin
					missed_nxt = 1'b1;
				// slave aligns start to master sync
				end else if (sync_rise) begin
					st_nxt = MGS_RUN;
					conv_start = 1'b1;
					synced_nxt = 1'b1;
				end
			end
			MGS_RUN: begin
				if (!conv_en) begin
					st_nxt = MGS_IDLE;
					pcnt_nxt = 4'h0;
				end
			end
			default: st_nxt = MGS_IDLE;
		endcase
		// leaving gang cuts a standing pulse
		if (!gang_on) begin
			pcnt_nxt = 4'h0;
		end
		// a fresh write of the control register clears the miss flag
		if (wr && paddr == MGS_MAIN_CTRL_OFS) begin
			missed_nxt = 1'b0;
			if (st_r == MGS_ARMED && sync_rise && !lock_s) begin
				missed_nxt = 1'b1; // set wins over clear
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= MGS_IDLE;
			pcnt_r <= 4'h0;
			synced_r <= 1'b0;
			missed_r <= 1'b0;
			sync_q_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			pcnt_r <= pcnt_nxt;
			synced_r <= synced_nxt;
			missed_r <= missed_nxt;
			sync_q_r <= sync_q_nxt;
		end
	end

	assign conv_run = (st_r == MGS_RUN);

	// ------------------------------------------------------------
	// pin direction control
	// ------------------------------------------------------------
	// master drives sync only in gang mode
	assign sync_oe = gang_on & is_master;
	// sync active high for the pulse width, dropped at once without gang
	assign sync_out = gang_on & (pcnt_r != 4'h0);
	// clock pin driven by gang master only
	assign clk_io_oe = gang_on & is_master;
	assign cal_io_oe = is_master & cal_r[MGS_CAL_OUT_BIT];
	assign cal_ext_sel = ~is_master & cal_r[MGS_CAL_EXT_BIT];

	// ------------------------------------------------------------
	// check helper: width of the standing sync pulse
	// ------------------------------------------------------------
	logic [3:0] hi_cnt_r, hi_cnt_nxt; // cycles sync_out has stood high
	// a small counter keeps the width check cheap for long pulses
	always_comb begin
		hi_cnt_nxt = 4'h0;
		// saturate so a stuck pin cannot wrap back to a legal width
		if (sync_out && hi_cnt_r != 4'hf) begin
			hi_cnt_nxt = hi_cnt_r + 4'h1;
		end else if (sync_out) begin
			hi_cnt_nxt = hi_cnt_r;
		end
	end
	// helper register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_cnt_r <= 4'h0;
		end else begin
			hi_cnt_r <= hi_cnt_nxt;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence start_seq;
		st_r == MGS_IDLE && conv_en && is_master && gang_on;
	endsequence

	role_select_a: assert property (@(posedge clk) disable iff (!reset_n)
		SLAVE_ONLY |-> !sync_oe && !clk_io_oe)
		else $error("slave-only variant drives a pin");
	gang_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
		!gang_on |-> !sync_oe && !clk_io_oe && !sync_out)
		else $error("pins active without gang");
	master_oe_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(gang_on && is_master) |-> sync_oe)
		else $error("master sync not output");
	slave_in_a: assert property (@(posedge clk) disable iff (!reset_n)
		!is_master |-> !sync_oe && !clk_io_oe)
		else $error("slave drives a pin");
	clk_hiz_a: assert property (@(posedge clk) disable iff (!reset_n)
		clk_io_oe |-> gang_on)
		else $error("clock pin driven out of gang");
	sync_hiz_a: assert property (@(posedge clk) disable iff (!reset_n)
		sync_oe |-> ctrl_r[MGS_GANG_BIT])
		else $error("sync pin driven out of gang");
	sync_once_a: assert property (@(posedge clk) disable iff (!reset_n)
		start_seq |=> sync_out)
		else $error("sync pulse did not start");
	sync_width_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(sync_out) && conv_en && gang_on
		|-> hi_cnt_r == MGS_SYNC_CYC_W)
		else $error("sync pulse wrong width");
	sync_norep_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(sync_out) |-> $past(st_r) == MGS_IDLE)
		else $error("sync repeated");
	slave_align_a: assert property (@(posedge clk) disable iff (!reset_n)
		st_r == MGS_ARMED && sync_rise && lock_s && conv_en && gang_on
		&& !is_master |=> conv_run && synced_r)
		else $error("slave failed to align");
	miss_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
		st_r == MGS_ARMED && sync_rise && !lock_s && conv_en && gang_on
		&& !is_master |=> missed_r && !conv_run)
		else $error("unlocked sync not flagged");
	cal_route_a: assert property (@(posedge clk) disable iff (!reset_n)
		!cal_r[MGS_CAL_OUT_BIT] |-> !cal_io_oe)
		else $error("cal pin driven unconfigured");
	sync_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
		st_r == MGS_IDLE && !conv_en |=> !conv_run)
		else $error("sync acted while disabled");
	conv_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		conv_start |=> conv_run)
		else $error("start did not lead to conversion");
	cal_ext_a: assert property (@(posedge clk) disable iff (!reset_n)
		cal_ext_sel |-> !is_master && cal_r[MGS_CAL_EXT_BIT])
		else $error("cal input taken unconfigured");
endmodule : mgs_gang_sync

// ==== rtl/mgs_sync2.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module mgs_sync2 (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// asynchronous level in, synchronised level out
	input wire logic din,
	output logic dout
);
	logic meta_r; // first stage, read only by the second
	// ------------------------------------------------------------
	// two-stage capture
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule : mgs_sync2

// ==== verif/mgs_far_dev.sv ====
// far ganged device: sends a sync pulse on the shared line
`timescale 1ns/1ns
module mgs_far_dev #(
	parameter int PULSE_CYC = 10 // pulse width in cycles
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// bench request for one pulse
	input wire logic fire,
	// sync pin drive
	output logic sync_o,
	output logic sync_oe
);
	// ------------------------------------------------------------
	// pulse generator
	// ------------------------------------------------------------
	logic [7:0] cnt_r; // cycles left to drive
	logic [7:0] cnt_nxt;
	// shared clock, one active-high pulse per request
	always_comb begin
		cnt_nxt = cnt_r;
		if (fire && cnt_r == 8'h00) begin
			cnt_nxt = 8'(PULSE_CYC);
		end else if (cnt_r != 8'h00) begin
			cnt_nxt = cnt_r - 8'h01;
		end
	end
	// count register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	// released line falls to the pull-down, not a held value
	assign sync_o = (cnt_r != 8'h00);
	assign sync_oe = (cnt_r != 8'h00);
endmodule : mgs_far_dev

// ==== verif/tb.sv ====
// bench: apb tasks and gang sync scenarios
`timescale 1ns/1ns
module tb;
	import mgs_pkg::*;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, pll_lock = 1'b0, fire = 1'b0;
	logic power_en, conv_start, conv_run, sync_out, sync_oe;
	logic clk_io_oe, cal_io_oe, cal_ext_sel, far_o, far_oe;
	int miscompares = 0, n_tests = 0, cyc = 0, n, n_start = 0;
	// sync line has a pull-down: idle or released reads low
	wire sync_pin = sync_oe ? sync_out : (far_oe ? far_o : 1'b0);
	always #2 clk = ~clk;
	mgs_gang_sync uut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pll_lock(pll_lock), .power_en(power_en),
		.conv_start(conv_start), .conv_run(conv_run),
		.sync_in(sync_pin), .sync_out(sync_out), .sync_oe(sync_oe),
		.clk_io_oe(clk_io_oe), .cal_io_oe(cal_io_oe),
		.cal_ext_sel(cal_ext_sel));
	mgs_far_dev #(.PULSE_CYC(MGS_SYNC_CYC)) far (.clk(clk),
		.reset_n(reset_n), .fire(fire), .sync_o(far_o), .sync_oe(far_oe));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask : chk
	// let updates land, then sample just after an edge
	task automatic settle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : settle
	task automatic count_sync(input int c);
		n = 0;
		repeat (c) begin
			settle(1);
			n += int'(sync_out === 1'b1);
		end
	endtask : count_sync
	task automatic pulse;
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask : pulse
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	// hang guard: the whole run needs well under 1000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// conversion starts, counted mid-cycle where the pulse has settled
	always @(negedge clk) begin
		if (conv_start === 1'b1) begin
			n_start <= n_start + 1;
		end
	end
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		settle(2);
		chk("pins", 32'h0, 32'({sync_oe, clk_io_oe}));
		chk("cal", 32'h0, 32'({cal_io_oe, cal_ext_sel}));
		apb(1'b0, MGS_MAIN_CTRL_OFS, 32'h0);
		chk("ctrl", MGS_MAIN_CTRL_RST, rd);
		$display("end reset test");
		// sync while unarmed is ignored
		pll_lock <= 1'b1;
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h02);
		pulse();
		settle(20);
		chk("run unarmed", 32'h0, 32'(conv_run));
		// armed slave without lock misses the pulse
		pll_lock <= 1'b0;
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h13);
		pulse();
		settle(20);
		chk("run no lock", 32'h0, 32'(conv_run));
		apb(1'b0, MGS_OP_STATUS_OFS, 32'h0);
		chk("missed", 32'h1, 32'(rd[MGS_MISSED_BIT]));
		$display("end unarmed test");
		// power, wait for lock, arm slave, then the master pulse
		// one device here: mode and rate duties are the host's
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h02);
		pll_lock <= 1'b1;
		settle(4);
		chk("power", 32'h1, 32'(power_en));
		apb(1'b0, MGS_OP_STATUS_OFS, 32'h0);
		chk("lock", 32'h1, 32'(rd[MGS_LOCK_BIT]));
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h13);
		settle(2);
		chk("slave pins", 32'h0, 32'({sync_oe, clk_io_oe}));
		chk("run armed", 32'h0, 32'(conv_run));
		pulse();
		settle(6);
		chk("run synced", 32'h1, 32'(conv_run));
		chk("starts", 32'h1, 32'(n_start));
		apb(1'b0, MGS_OP_STATUS_OFS, 32'h0);
		chk("slave status", 32'((1 << MGS_LOCK_BIT) | (1 << MGS_RUN_BIT) |
			(1 << MGS_SYNCED_BIT)), rd & 32'h0000_001f);
		$display("end slave test");
		// master without gang: converts, no pulse, pins float
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h0);
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h21);
		count_sync(30);
		chk("no gang pulse", 32'h0, 32'(n));
		chk("no gang pins", 32'h0, 32'({sync_oe, clk_io_oe}));
		chk("no gang run", 32'h1, 32'(conv_run));
		chk("starts", 32'h2, 32'(n_start));
		// ganged master drives pins and pulses once
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h0);
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h30);
		settle(1);
		chk("master pins", 32'h3, 32'({sync_oe, clk_io_oe}));
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h31);
		count_sync(40);
		chk("sync width", 32'(MGS_SYNC_CYC), 32'(n));
		chk("master run", 32'h1, 32'(conv_run));
		chk("starts", 32'h3, 32'(n_start));
		apb(1'b0, MGS_OP_STATUS_OFS, 32'h0);
		chk("master", 32'h1, 32'(rd[MGS_IS_MASTER_BIT]));
		$display("end master test");
		// calibration routing only on request; unmapped reads 0
		apb(1'b1, MGS_CAL_CTRL_OFS, 32'h3);
		settle(1);
		chk("cal route", 32'h2, 32'({cal_io_oe, cal_ext_sel}));
		apb(1'b1, MGS_MAIN_CTRL_OFS, 32'h0);
		settle(1);
		chk("cal slave", 32'h1, 32'({cal_io_oe, cal_ext_sel}));
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("slverr", 32'h0, 32'(pslverr));
		$display("end cal test");
		report_and_stop();
	end
endmodule : tb
